/* File: dv/host_model.sv */
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // Write data is inverted once the strobe drops, so a stale value never passes for a fresh one.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    d = reg_rdata;
  endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  localparam int unsigned MS = 4;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic ov_per = 1'b0;
  logic th_per = 1'b1;
  logic skip = 1'b0;
  logic sleep = 1'b0;
  logic [15:0] count = 16'h0000;
  logic [7:0] sample = 8'h00;
  logic boost_req = 1'b1;
  logic en_pin_n = 1'b0;
  logic wake_cmp = 1'b0;
  logic hot = 1'b0;
  logic [7:0] addr, wdata, rdata, result;
  logic wr, active, done, th_check, tripped, boost_en, dev_en, wake;
  logic [2:0] peak;
  int bad_count = 0;
  int compares = 0;

  always #12.5 clock = ~clock;

  host_model u_host_model (
    .clock(clock),
    .reg_addr(addr),
    .reg_wr(wr),
    .reg_wdata(wdata),
    .reg_rdata(rdata)
  );

  harv_ctrl #(.MS_CYCLES(MS)) u_harv_ctrl (
    .CLOCK(clock),
    .ARST_N(arst_n),
    .REG_ADDR(addr),
    .REG_WR(wr),
    .REG_WDATA(wdata),
    .REG_RDATA(rdata),
    .OPEN_VOLT_PERIODIC_EN(ov_per),
    .THERMAL_PERIODIC_EN(th_per),
    .SKIP_OPEN_CIRCUIT_MEASURE(skip),
    .SLEEP(sleep),
    .HARVEST_PULSE_COUNT(count),
    .OPEN_VOLT_SAMPLE(sample),
    .BOOST_LOGIC_EN(boost_req),
    .ENABLE_PIN_N(en_pin_n),
    .WAKE_COMPARATOR(wake_cmp),
    .THERMAL_OVER_TEMP(hot),
    .OPEN_VOLT_MEAS_ACTIVE(active),
    .OPEN_VOLT_MEAS_DONE(done),
    .THERMAL_CHECK(th_check),
    .THERMAL_TRIPPED(tripped),
    .OPEN_CIRCUIT_RESULT(result),
    .BOOST_PEAK_SEL(peak),
    .BOOST_EN(boost_en),
    .DEVICE_EN(dev_en),
    .WAKE(wake)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host_model.read(a, d);
    check(16'(d), 16'(exp), "register read");
  endtask

  // Bounded so that a measurement that never ends shows up as a wrong length, not a hang.
  task automatic settle(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (done !== 1'b1 && n < 3000);
  endtask

  task automatic in_range(input int n, input int lo_ms, input string what);
    check(16'(n >= lo_ms * MS + 1 && n <= (lo_ms + 1) * MS + 6), 16'h0001, what);
  endtask

  task automatic watch(input int n, output int starts, output int checks);
    logic prev;
    starts = 0;
    checks = 0;
    prev = active;
    repeat (n) begin
      @(negedge clock);
      if (active === 1'b1 && prev !== 1'b1) starts++;
      if (th_check === 1'b1) checks++;
      prev = active;
    end
  endtask

  task automatic pins(input logic w, input logic d, input logic b);
    repeat (8) @(negedge clock);
    check(16'(wake), 16'(w), "wake output");
    check(16'(dev_en), 16'(d), "device enable");
    check(16'(boost_en), 16'(b), "boost enable");
  endtask

  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #(50000 * 25);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    int n, s, c;
    int tm[4] = '{50, 100, 250, 500};
    logic [2:0] ovr[4] = '{3'h0, 3'h4, 3'h2, 3'h1};
    logic [15:0] acnt[2] = '{16'hc000, 16'h0000};
    int ams[2] = '{12, 100};
    repeat (20) @(negedge clock);
    arst_n = 1'b1;
    rd(8'h07, 8'h0e);
    rd(8'h08, 8'h30);
    rd(8'h09, 8'h1d);
    rd(8'h10, 8'h00);
    check(16'(peak), 16'h0003, "peak at reset");
    watch(200, s, c);
    check(16'(s), 16'h0000, "power-on measurement");
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      u_host_model.write(8'h08, {1'b1, 3'(k), 4'h0});
      repeat (2) @(negedge clock);
      check(16'(peak), 16'(k), "peak select");
      rd(8'h08, {1'b0, 3'(k), 4'h0});
    end
    for (int k = 0; k < 4; k++) begin
      u_host_model.write(8'h08, {5'h03, ovr[k]});
      pins(ovr[k][2], !ovr[k][1], !ovr[k][1] && !ovr[k][0]);
    end
    wake_cmp = 1'b1;
    boost_req = 1'b0;
    pins(1'b1, 1'b1, 1'b0);
    en_pin_n = 1'b1;
    pins(1'b1, 1'b0, 1'b0);
    en_pin_n = 1'b0;
    boost_req = 1'b1;
    wake_cmp = 1'b0;
    $display("test device control done");
    for (int k = 0; k < 4; k++) begin
      sample = 8'h40 + 8'(k);
      u_host_model.write(8'h07, {2'h3, 2'(k), 4'h3});
      settle(n);
      in_range(n, tm[k], "fixed settle time");
      check(16'(result), 16'(sample), "measured result");
      rd(8'h07, {2'h0, 2'(k), 4'h3});
    end
    skip = 1'b1;
    u_host_model.write(8'h07, 8'h83);
    watch(40, s, c);
    check(16'(s), 16'h0000, "skipped request");
    skip = 1'b0;
    for (int k = 0; k < 2; k++) begin
      count = acnt[k];
      u_host_model.write(8'h07, 8'h8b);
      settle(n);
      in_range(n, ams[k], "adaptive settle time");
    end
    u_host_model.write(8'h09, 8'h5a);
    rd(8'h09, 8'h5a);
    check(16'(result), 16'h005a, "written result");
    $display("test measurement done");
    hot = 1'b1;
    u_host_model.write(8'h08, 8'h30);
    u_host_model.write(8'h07, 8'h43);
    watch(10, s, c);
    check(16'(c), 16'h0000, "thermal off check");
    check(16'(boost_en), 16'h0001, "boost with thermal off");
    u_host_model.write(8'h08, 8'h38);
    u_host_model.write(8'h07, 8'h43);
    watch(10, s, c);
    check(16'(c), 16'h0001, "forced thermal check");
    check(16'(tripped), 16'h0001, "thermal trip");
    check(16'(boost_en), 16'h0000, "boost stopped hot");
    u_host_model.write(8'h08, 8'h30);
    repeat (3) @(negedge clock);
    check(16'(tripped), 16'h0000, "trip cleared");
    check(16'(boost_en), 16'h0001, "boost back");
    hot = 1'b0;
    $display("test thermal done");
    count = 16'd1000;
    u_host_model.write(8'h07, 8'h86);
    settle(n);
    count = 16'd3000;
    watch(2 * 50 * MS - 8, s, c);
    check(16'(s), 16'h0000, "early store");
    // A store taken too early would hold 3000 and this count would then trigger a re-measure.
    count = 16'd7000;
    watch(20, s, c);
    check(16'(s), 16'h0000, "count stored");
    sleep = 1'b1;
    count = 16'd1000;
    watch(40, s, c);
    check(16'(s), 16'h0000, "asleep");
    sleep = 1'b0;
    watch(10, s, c);
    check(16'(s), 16'h0001, "ratio re-measure");
    settle(n);
    $display("test adaptive period done");
    ov_per = 1'b1;
    u_host_model.write(8'h08, 8'h38);
    u_host_model.write(8'h07, 8'h80);
    watch(64 * 50 * MS - 10, s, c);
    check(16'(s), 16'h0001, "forced start before period");
    check(16'(c), 16'h0000, "before period");
    watch(30, s, c);
    check(16'(s), 16'h0001, "periodic measure");
    check(16'(c), 16'h0001, "periodic thermal");
    u_host_model.write(8'h07, 8'h03);
    watch(13000, s, c);
    check(16'(s + c), 16'h0000, "period disabled");
    $display("test period done");
    arst_n = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    watch(20, s, c);
    check(16'(s), 16'h0001, "power-on measurement enabled");
    check(16'(c), 16'h0000, "no thermal after reset");
    $display("test power-on done");
    wrap_up();
  end
endmodule

/* File: verilog/harv_ctrl.sv */
`timescale 1ns/100ps
`include "harv_params.svh"
module harv_ctrl #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // Register port from the serial engine
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Settings held in neighbouring registers
  input wire logic OPEN_VOLT_PERIODIC_EN,
  input wire logic THERMAL_PERIODIC_EN,
  input wire logic SKIP_OPEN_CIRCUIT_MEASURE,
  input wire logic SLEEP,
  // Harvester core
  input wire logic [15:0] HARVEST_PULSE_COUNT,
  input wire logic [7:0] OPEN_VOLT_SAMPLE,
  input wire logic BOOST_LOGIC_EN,
  // Pins and comparators
  input wire logic ENABLE_PIN_N,
  input wire logic WAKE_COMPARATOR,
  input wire logic THERMAL_OVER_TEMP,
  // Measurement and control outputs
  output logic OPEN_VOLT_MEAS_ACTIVE,
  output logic OPEN_VOLT_MEAS_DONE,
  output logic THERMAL_CHECK,
  output logic THERMAL_TRIPPED,
  output logic [7:0] OPEN_CIRCUIT_RESULT,
  output logic [2:0] BOOST_PEAK_SEL,
  output logic BOOST_EN,
  output logic DEVICE_EN,
  output logic WAKE
);
  localparam logic [2:0] PIN_RESET = 3'h1;

  // Pin index 0 enable pin, 1 wake comparator, 2 over-temperature.
  wire [2:0] pin_raw = {THERMAL_OVER_TEMP, WAKE_COMPARATOR, ENABLE_PIN_N};
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pin_q;

  logic [5:0] meas_cfg_q;
  logic [6:0] dev_ctl_q;
  logic [7:0] oc_result_q;
  logic ov_pend_q;
  logic th_pend_q;
  logic por_pend_q;
  harv_pkg::sched_e state_q;
  harv_pkg::sched_e state_d;
  harv_pkg::adapt_e adp_q;
  harv_pkg::adapt_e adp_d;
  harv_pkg::ms_t wait_q;
  logic [15:0] stored_cnt_q;
  logic active_q;
  logic done_q;
  logic check_q;
  logic trip_q;
  logic [2:0] peak_q;
  logic boost_q;
  logic dev_en_q;
  logic wake_q;
  logic [7:0] rdata_q;

  timer_if tif();

  meas_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .tif(tif.timer)
  );

  function automatic harv_pkg::ms_t tmeas_ms(input logic [1:0] code);
    harv_pkg::ms_t ms;
    ms = 11'h000;
    unique case (code)
      2'h0: ms = 11'(`TMEAS_00_MS);
      2'h1: ms = 11'(`TMEAS_01_MS);
      2'h2: ms = 11'(`TMEAS_10_MS);
      2'h3: ms = 11'(`TMEAS_11_MS);
    endcase
    return ms;
  endfunction

  // Outside levels pass three flops; a change counts once the last two agree.
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
        sync1_q[i] <= PIN_RESET[i];
        sync2_q[i] <= PIN_RESET[i];
        sync3_q[i] <= PIN_RESET[i];
        pin_q[i] <= PIN_RESET[i];
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
        sync3_q[i] <= sync2_q[i];
        pin_q[i] <= (sync2_q[i] == sync3_q[i]) ? sync2_q[i] : pin_q[i];
      end
    end
  end

  // Decode.
  wire cfg_wr = REG_WR && (REG_ADDR == `MEAS_CFG_ADDR);
  wire dev_wr = REG_WR && (REG_ADDR == `DEV_CTL_ADDR);
  wire res_wr = REG_WR && (REG_ADDR == `OC_RESULT_ADDR);
  wire [1:0] tmeas = meas_cfg_q[`TMEAS_MSB:`TMEAS_LSB];
  wire [1:0] tper = meas_cfg_q[`TPER_MSB:`TPER_LSB];
  wire adapt_settle = meas_cfg_q[`ADAPT_SETTLE_BIT];
  wire thermal_en = dev_ctl_q[`THERMAL_EN_BIT];
  wire wake_ovr = dev_ctl_q[`WAKE_OVR_BIT];
  wire dev_dis = dev_ctl_q[`DEV_DIS_BIT];
  wire boost_dis = dev_ctl_q[`BOOST_DIS_BIT];
  wire auto_on = tper != `TPER_DISABLED;
  wire adapt_on = meas_cfg_q[`ADAPT_PERIOD_BIT] && auto_on;
  wire harv_pkg::ms_t tm = tmeas_ms(tmeas);

  // High pulse count means a strong source, which settles quickly.
  wire harv_pkg::ms_t adapt_ms = (HARVEST_PULSE_COUNT[15:14] == 2'h3) ? (tm >> 2) :
                                 (HARVEST_PULSE_COUNT[15:14] == 2'h2) ? (tm >> 1) :
                                 (HARVEST_PULSE_COUNT[15:14] == 2'h1) ? tm : (tm << 1);
  wire harv_pkg::ms_t settle_ms = adapt_settle ? adapt_ms : tm;
  wire harv_pkg::period_t period_ms = 17'(tm) << (`PERIOD_SHIFT_BASE + tper);

  // Automatic and forced requests.
  wire auto_tick = tif.period_expired && auto_on;
  wire auto_ov = auto_tick && OPEN_VOLT_PERIODIC_EN;
  wire auto_th = auto_tick && THERMAL_PERIODIC_EN && thermal_en;
  wire por_ov = por_pend_q && OPEN_VOLT_PERIODIC_EN && auto_on;
  wire force_ov_wr = cfg_wr && REG_WDATA[`FORCE_OV_BIT];
  wire force_th_wr = cfg_wr && REG_WDATA[`FORCE_TH_BIT] && thermal_en;
  wire [16:0] cnt_x2 = {HARVEST_PULSE_COUNT, 1'b0};
  wire [16:0] stored_x2 = {stored_cnt_q, 1'b0};
  wire ratio_low = cnt_x2 < {1'b0, stored_cnt_q};
  wire ratio_high = {1'b0, HARVEST_PULSE_COUNT} > stored_x2;
  wire adapt_trig = (adp_q == harv_pkg::ADP_ARMED) && adapt_on && !SLEEP && (ratio_low || ratio_high);
  wire ov_set = force_ov_wr || auto_ov || por_ov || adapt_trig;
  wire ov_go = ov_pend_q && !SKIP_OPEN_CIRCUIT_MEASURE && (state_q == harv_pkg::SCHED_IDLE);
  wire ov_drop = ov_pend_q && SKIP_OPEN_CIRCUIT_MEASURE;
  wire ov_end = (state_q == harv_pkg::SCHED_SETTLE) && tif.settle_done;
  wire th_go = (th_pend_q || auto_th) && thermal_en;
  wire wait_over = tif.ms_tick && ({1'b0, wait_q} >= {tm, 1'b0});

  assign tif.settle_load = ov_go;
  assign tif.settle_ms = settle_ms;
  assign tif.period_restart = ov_go;
  assign tif.period_ms = period_ms;

  wire [7:0] rdata_d = (REG_ADDR == `MEAS_CFG_ADDR) ? {2'h0, meas_cfg_q} :
                       (REG_ADDR == `DEV_CTL_ADDR) ? {1'h0, dev_ctl_q} :
                       (REG_ADDR == `OC_RESULT_ADDR) ? oc_result_q : 8'h00;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      harv_pkg::SCHED_IDLE: begin
        if (ov_go) begin
          state_d = harv_pkg::SCHED_SETTLE;
        end
      end
      harv_pkg::SCHED_SETTLE: begin
        if (tif.settle_done) begin
          state_d = harv_pkg::SCHED_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    adp_d = adp_q;
    unique case (adp_q)
      harv_pkg::ADP_IDLE: begin
        if (ov_end && adapt_on) begin
          adp_d = harv_pkg::ADP_WAIT;
        end
      end
      harv_pkg::ADP_WAIT: begin
        if (!adapt_on || ov_go) begin
          adp_d = harv_pkg::ADP_IDLE;
        end else if (wait_over) begin
          adp_d = harv_pkg::ADP_ARMED;
        end
      end
      harv_pkg::ADP_ARMED: begin
        if (!adapt_on || ov_go || adapt_trig) begin
          adp_d = harv_pkg::ADP_IDLE;
        end
      end
      default: adp_d = harv_pkg::ADP_IDLE;
    endcase
  end

  // Registers written by the host.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      meas_cfg_q <= `MEAS_CFG_RESET;
      dev_ctl_q <= `DEV_CTL_RESET;
    end else begin
      meas_cfg_q <= cfg_wr ? REG_WDATA[5:0] : meas_cfg_q;
      dev_ctl_q <= dev_wr ? REG_WDATA[6:0] : dev_ctl_q;
    end
  end

  // A host write wins over a sample landing in the same cycle.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      oc_result_q <= `OC_RESULT_RESET;
    end else if (res_wr) begin
      oc_result_q <= REG_WDATA;
    end else if (ov_end) begin
      oc_result_q <= OPEN_VOLT_SAMPLE;
    end
  end

  // Requests: a new request in the cycle of its clear is kept.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ov_pend_q <= 1'b0;
      th_pend_q <= 1'b0;
      por_pend_q <= 1'b1;
    end else begin
      ov_pend_q <= ov_set || (ov_pend_q && !(ov_go || ov_drop));
      th_pend_q <= force_th_wr;
      por_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= harv_pkg::SCHED_IDLE;
      adp_q <= harv_pkg::ADP_IDLE;
      wait_q <= 11'h000;
      stored_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      adp_q <= adp_d;
      wait_q <= (adp_q != harv_pkg::ADP_WAIT) ? 11'h000 : (tif.ms_tick ? wait_q + 11'h001 : wait_q);
      stored_cnt_q <= ((adp_q == harv_pkg::ADP_WAIT) && wait_over) ? HARVEST_PULSE_COUNT : stored_cnt_q;
    end
  end

  // Outputs.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      active_q <= 1'b0;
      done_q <= 1'b0;
      check_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      active_q <= state_d == harv_pkg::SCHED_SETTLE;
      done_q <= ov_end;
      check_q <= th_go;
      trip_q <= thermal_en && (th_go ? pin_q[2] : trip_q);
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      peak_q <= 3'h3;
      boost_q <= 1'b0;
      dev_en_q <= 1'b0;
      wake_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      peak_q <= dev_ctl_q[`PEAK_MSB:`PEAK_LSB];
      boost_q <= !boost_dis && BOOST_LOGIC_EN && !trip_q && !dev_dis && !pin_q[0];
      dev_en_q <= !dev_dis && !pin_q[0];
      wake_q <= wake_ovr || pin_q[1];
      rdata_q <= rdata_d;
    end
  end

  assign OPEN_VOLT_MEAS_ACTIVE = active_q;
  assign OPEN_VOLT_MEAS_DONE = done_q;
  assign THERMAL_CHECK = check_q;
  assign THERMAL_TRIPPED = trip_q;
  assign OPEN_CIRCUIT_RESULT = oc_result_q;
  assign BOOST_PEAK_SEL = peak_q;
  assign BOOST_EN = boost_q;
  assign DEVICE_EN = dev_en_q;
  assign WAKE = wake_q;
  assign REG_RDATA = rdata_q;

  force_start_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (force_ov_wr && (state_q == harv_pkg::SCHED_IDLE)) ##1 !SKIP_OPEN_CIRCUIT_MEASURE |=> OPEN_VOLT_MEAS_ACTIVE)
    else $error("forced measurement did not start");

  skip_drop_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ov_pend_q && SKIP_OPEN_CIRCUIT_MEASURE && !ov_set |=> !ov_pend_q)
    else $error("request kept while skipping");

  force_read_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    REG_ADDR == `MEAS_CFG_ADDR |=> REG_RDATA[7:6] == 2'h0 && REG_RDATA[5:0] == $past(meas_cfg_q))
    else $error("config readback wrong");

  thermal_gate_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    THERMAL_CHECK |-> $past(thermal_en))
    else $error("thermal check while disabled");

  thermal_off_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !thermal_en |=> !THERMAL_TRIPPED)
    else $error("thermal trip while disabled");

  wake_force_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    wake_ovr || pin_q[1] |=> WAKE)
    else $error("wake not high");

  dev_disable_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    dev_dis || pin_q[0] |=> !DEVICE_EN)
    else $error("device enabled while disabled");

  boost_disable_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    boost_dis || trip_q |=> !BOOST_EN)
    else $error("boost on while disabled");

  no_auto_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !auto_on && !cfg_wr && !ov_pend_q && !th_pend_q |=> !ov_pend_q && !THERMAL_CHECK)
    else $error("automatic measurement while disabled");

  peak_follow_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    dev_wr |=> ##1 BOOST_PEAK_SEL == $past(REG_WDATA[6:4], 2))
    else $error("peak select not updated");
endmodule

/* File: verilog/harv_params.svh */
`ifndef HARV_PARAMS_SVH
`define HARV_PARAMS_SVH
// How it works
// - Force-measure write starts an open-voltage measurement unless skipping; bit self-clears.
// - Force-thermal write triggers one thermal check only while thermal monitoring is on.
// - Measurement time code selects 50, 100, 250 or 500 ms.
// - Adaptive settling off: settling time equals the selected measurement time.
// - Adaptive settling on: settling follows pulse count, quarter to twice measurement time.
// - Adaptive period with automatic mode: store pulse count two measurement times later.
// - Awake and count ratio below half or above two forces a new measurement.
// - Automatic mode disabled: no self-started open-voltage or thermal measurement.
// - Three-bit peak-current field drives the boost peak current select.
// - Thermal enable low: no thermal checks and temperature never stops the boost.
// - Thermal checks run each period or on request and may stop the boost.
// - Wake output follows comparator, or is forced high by the override bit.
// - Device enable follows the active-low pin unless the disable bit is set.
// - Boost follows internal logic while the device is enabled, unless the boost-disable bit is set.
// - Periodic open-voltage enable low: measure on request or count-ratio trigger only, no power-on measurement.
// - Periodic thermal enable gives a check every period when monitoring is on.
// - Host writes to the result register replace the measured value.

// Register addresses.
`define MEAS_CFG_ADDR 8'h07
`define DEV_CTL_ADDR 8'h08
`define OC_RESULT_ADDR 8'h09

// Reset values.
`define MEAS_CFG_RESET 6'h0e
`define DEV_CTL_RESET 7'h30
`define OC_RESULT_RESET 8'h1d

// Measurement configuration fields.
`define FORCE_OV_BIT 7
`define FORCE_TH_BIT 6
`define TMEAS_MSB 5
`define TMEAS_LSB 4
`define ADAPT_SETTLE_BIT 3
`define ADAPT_PERIOD_BIT 2
`define TPER_MSB 1
`define TPER_LSB 0
`define TPER_DISABLED 2'h3

// Device control fields.
`define PEAK_MSB 6
`define PEAK_LSB 4
`define THERMAL_EN_BIT 3
`define WAKE_OVR_BIT 2
`define DEV_DIS_BIT 1
`define BOOST_DIS_BIT 0

// Timing.
`define TMEAS_00_MS 50
`define TMEAS_01_MS 100
`define TMEAS_10_MS 250
`define TMEAS_11_MS 500
`define PERIOD_SHIFT_BASE 6
`define CLOCK_HZ 40000000
`define MS_PER_S 1000
`define MS_CYCLES_DEFAULT (`CLOCK_HZ / `MS_PER_S)
`endif

/* File: verilog/harv_pkg.sv */
package harv_pkg;
  typedef enum logic [0:0] {
    SCHED_IDLE = 1'b0,
    SCHED_SETTLE = 1'b1
  } sched_e;

  typedef enum logic [1:0] {
    ADP_IDLE = 2'b00,
    ADP_WAIT = 2'b01,
    ADP_ARMED = 2'b10
  } adapt_e;

  typedef logic [10:0] ms_t;
  typedef logic [16:0] period_t;
endpackage

/* File: verilog/meas_timer.sv */
`timescale 1ns/100ps
`include "harv_params.svh"
module meas_timer #(
  parameter int unsigned MS_CYCLES = `MS_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Scheduler side
  timer_if.timer tif
);
  logic [15:0] presc_q;
  logic tick_q;
  harv_pkg::ms_t settle_cnt_q;
  logic settle_run_q;
  logic settle_done_q;
  harv_pkg::period_t per_cnt_q;
  logic per_exp_q;
  wire presc_wrap = presc_q == 16'(MS_CYCLES - 1);
  wire [16:0] per_next = per_cnt_q + 17'h00001;

  assign tif.ms_tick = tick_q;
  assign tif.settle_done = settle_done_q;
  assign tif.period_expired = per_exp_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      presc_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      presc_q <= presc_wrap ? 16'h0000 : presc_q + 16'h0001;
      tick_q <= presc_wrap;
    end
  end

  // One tick more than loaded, so a partial first millisecond never shortens settling.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt_q <= 11'h000;
      settle_run_q <= 1'b0;
      settle_done_q <= 1'b0;
    end else if (tif.settle_load) begin
      settle_cnt_q <= tif.settle_ms;
      settle_run_q <= 1'b1;
      settle_done_q <= 1'b0;
    end else if (tick_q && settle_run_q) begin
      settle_run_q <= settle_cnt_q != 11'h000;
      settle_done_q <= settle_cnt_q == 11'h000;
      settle_cnt_q <= (settle_cnt_q == 11'h000) ? 11'h000 : settle_cnt_q - 11'h001;
    end else begin
      settle_done_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      per_cnt_q <= 17'h00000;
      per_exp_q <= 1'b0;
    end else if (tif.period_restart) begin
      per_cnt_q <= 17'h00000;
      per_exp_q <= 1'b0;
    end else if (tick_q) begin
      per_exp_q <= per_next >= tif.period_ms;
      per_cnt_q <= (per_next >= tif.period_ms) ? 17'h00000 : per_next;
    end else begin
      per_exp_q <= 1'b0;
    end
  end
endmodule

/* File: verilog/timer_if.sv */
`timescale 1ns/100ps
interface timer_if;
  logic ms_tick;
  logic settle_load;
  harv_pkg::ms_t settle_ms;
  logic settle_done;
  logic period_restart;
  harv_pkg::period_t period_ms;
  logic period_expired;

  modport ctrl (
    input ms_tick,
    input settle_done,
    input period_expired,
    output settle_load,
    output settle_ms,
    output period_restart,
    output period_ms
  );

  modport timer (
    output ms_tick,
    output settle_done,
    output period_expired,
    input settle_load,
    input settle_ms,
    input period_restart,
    input period_ms
  );
endinterface
